// file: src/osc_ctrl_pkg.sv
package osc_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Peripheral addressing
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PERIPH_NUMBER = 8'h04;
  localparam logic [7:0] OFFSET_GENERAL = 8'h00;
  localparam logic [7:0] OFFSET_INTERNAL = 8'h01;
  localparam logic [7:0] OFFSET_CRYSTAL = 8'h02;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int GEN_SOURCE_BIT = 0;
  localparam int GEN_RESET_ON_CHANGE_BIT = 1;
  localparam int INT_ENABLE_BIT = 0;
  localparam int INT_SLOW_BIT = 1;
  localparam int XTAL_ENABLE_BIT = 0;
  localparam int XTAL_BIAS_BIT = 1;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic RESET_RESET_ON_CHANGE = 1'b0;
  localparam logic RESET_INT_SLOW = 1'b0;
  localparam logic RESET_INT_ENABLE = 1'b1;
  localparam logic RESET_XTAL_BIAS = 1'b1;
  localparam logic RESET_XTAL_ENABLE = 1'b1;
  localparam logic RESET_SOURCE = 1'b0;

  // Tile reset pulse length in clock cycles
  localparam logic [3:0] TILE_RESET_CYCLES = 4'h4;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] periph;
    logic [7:0] offset;
    logic [7:0] wdata;
  } periph_req_t;

  typedef struct packed {
    logic source_internal;
    logic internal_enable;
    logic internal_slow;
    logic crystal_enable;
    logic crystal_bias;
  } osc_ctrl_t;

  typedef enum logic [1:0] {
    STRAP_WAIT = 2'b01,
    RUNNING = 2'b10
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic reset_on_change;
    osc_ctrl_t osc;
    logic [7:0] rdata;
    logic rvalid;
    logic tile_reset;
    logic [3:0] tile_reset_count;
  } state_t;

endpackage

// file: src/oscillator_select_control.sv
`timescale 1ns/1ps
// Summary of operation
// - The block answers as peripheral 4 and every register access is an 8-bit read or write.
// - General bit 0 picks the clock source, 0 crystal and 1 internal, loaded from a strap.
// - With general bit 1 set a change of the source bit resets the tile; it resets to 0.
// - Internal control bit 1 picks fast (about 20 MHz) at 0 or slow (about 31,250 Hz) at 1.
// - Internal control bit 0 enables the internal oscillator, resets to 1, 0 stops it.
// - Crystal control bit 1 enables the crystal bias, resets to 1, 0 switches it off.
// - Crystal control bit 0 enables the crystal oscillator, resets to 1, 0 stops it.
module oscillator_select_control (
  input wire logic clock,
  input wire logic rst,
  input wire osc_ctrl_pkg::periph_req_t req,
  input wire logic source_strap,
  output logic [7:0] rdata,
  output logic rvalid,
  output osc_ctrl_pkg::osc_ctrl_t osc,
  output logic tile_reset
);

  osc_ctrl_pkg::state_t state;
  osc_ctrl_pkg::state_t next_state;

  // ---------------------------------------------------------------------------
  // Register images
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] general_image(input osc_ctrl_pkg::state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[osc_ctrl_pkg::GEN_SOURCE_BIT] = s.osc.source_internal;
    v[osc_ctrl_pkg::GEN_RESET_ON_CHANGE_BIT] = s.reset_on_change;
    return v;
  endfunction

  function automatic logic [7:0] internal_image(input osc_ctrl_pkg::state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[osc_ctrl_pkg::INT_ENABLE_BIT] = s.osc.internal_enable;
    v[osc_ctrl_pkg::INT_SLOW_BIT] = s.osc.internal_slow;
    return v;
  endfunction

  function automatic logic [7:0] crystal_image(input osc_ctrl_pkg::state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[osc_ctrl_pkg::XTAL_ENABLE_BIT] = s.osc.crystal_enable;
    v[osc_ctrl_pkg::XTAL_BIAS_BIT] = s.osc.crystal_bias;
    return v;
  endfunction

  // Unmapped offsets read as zero rather than echoing stale data
  function automatic logic [7:0] read_reg(input osc_ctrl_pkg::state_t s, input logic [7:0] off);
    logic [7:0] v;
    v = 8'h00;
    case (off)
      osc_ctrl_pkg::OFFSET_GENERAL: begin
        v = general_image(s);
      end
      osc_ctrl_pkg::OFFSET_INTERNAL: begin
        v = internal_image(s);
      end
      osc_ctrl_pkg::OFFSET_CRYSTAL: begin
        v = crystal_image(s);
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------------------
  // Only bits 1 and 0 are stored, so reserved write bits fall away here
  function automatic osc_ctrl_pkg::state_t apply_write(input osc_ctrl_pkg::state_t s,
                                                       input logic [7:0] off,
                                                       input logic [7:0] d);
    osc_ctrl_pkg::state_t n;
    n = s;
    case (off)
      osc_ctrl_pkg::OFFSET_GENERAL: begin
        n.osc.source_internal = d[osc_ctrl_pkg::GEN_SOURCE_BIT];
        n.reset_on_change = d[osc_ctrl_pkg::GEN_RESET_ON_CHANGE_BIT];
      end
      osc_ctrl_pkg::OFFSET_INTERNAL: begin
        n.osc.internal_slow = d[osc_ctrl_pkg::INT_SLOW_BIT];
        n.osc.internal_enable = d[osc_ctrl_pkg::INT_ENABLE_BIT];
      end
      osc_ctrl_pkg::OFFSET_CRYSTAL: begin
        n.osc.crystal_bias = d[osc_ctrl_pkg::XTAL_BIAS_BIT];
        n.osc.crystal_enable = d[osc_ctrl_pkg::XTAL_ENABLE_BIT];
      end
      default: begin
        // Writes to unmapped offsets are dropped
        n = s;
      end
    endcase
    return n;
  endfunction

  // ---------------------------------------------------------------------------
  // Tile reset counter
  // ---------------------------------------------------------------------------
  // A fresh change restarts the pulse, so the tile always sees the full length
  function automatic logic [3:0] tile_countdown(input logic [3:0] count, input logic restart);
    logic [3:0] n;
    n = count;
    if (restart) begin
      n = osc_ctrl_pkg::TILE_RESET_CYCLES;
    end else if (count != 4'h0) begin
      n = count - 4'h1;
    end
    return n;
  endfunction

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic selected;
    logic changed;
    selected = 1'b0;
    changed = 1'b0;
    next_state = state;
    next_state.rvalid = 1'b0;
    selected = (req.periph == osc_ctrl_pkg::PERIPH_NUMBER);
    case (state.phase)
      osc_ctrl_pkg::STRAP_WAIT: begin
        // Strap is caught after release, never under the async reset
        next_state.osc.source_internal = source_strap;
        next_state.phase = osc_ctrl_pkg::RUNNING;
      end
      osc_ctrl_pkg::RUNNING: begin
        if (selected && req.write) begin
          next_state = apply_write(next_state, req.offset, req.wdata);
        end
        // Uses the enable held before this write, so one write sets both fields cleanly
        changed = state.reset_on_change &&
                  (next_state.osc.source_internal != state.osc.source_internal);
        next_state.tile_reset_count = tile_countdown(state.tile_reset_count, changed);
        if (selected && req.read) begin
          next_state.rdata = read_reg(state, req.offset);
          next_state.rvalid = 1'b1;
        end
      end
      default: next_state.phase = osc_ctrl_pkg::STRAP_WAIT;
    endcase
    next_state.tile_reset = (next_state.tile_reset_count != 4'h0);
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state.phase <= osc_ctrl_pkg::STRAP_WAIT;
      state.reset_on_change <= osc_ctrl_pkg::RESET_RESET_ON_CHANGE;
      state.osc.source_internal <= osc_ctrl_pkg::RESET_SOURCE;
      state.osc.internal_enable <= osc_ctrl_pkg::RESET_INT_ENABLE;
      state.osc.internal_slow <= osc_ctrl_pkg::RESET_INT_SLOW;
      state.osc.crystal_enable <= osc_ctrl_pkg::RESET_XTAL_ENABLE;
      state.osc.crystal_bias <= osc_ctrl_pkg::RESET_XTAL_BIAS;
      state.rdata <= 8'h00;
      state.rvalid <= 1'b0;
      state.tile_reset <= 1'b0;
      state.tile_reset_count <= 4'h0;
    end else begin
      state <= next_state;
    end
  end

  assign rdata = state.rdata;
  assign rvalid = state.rvalid;
  assign osc = state.osc;
  assign tile_reset = state.tile_reset;

endmodule

// file: testbench/osc_ctrl_properties.sv
`timescale 1ns/1ps
module osc_ctrl_properties (
  input wire logic clock,
  input wire logic rst,
  input wire osc_ctrl_pkg::periph_req_t req,
  input wire logic source_strap,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire osc_ctrl_pkg::osc_ctrl_t osc,
  input wire logic tile_reset
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic hit;
  assign hit = req.write && req.periph == 8'h04;
  sequence s_pulse;
    tile_reset [*4] ##1 !tile_reset;
  endsequence
  a_read_answer: assert property (req.read && req.periph == 8'h04 |=> rvalid)
    else $error("read not answered");
  a_foreign_quiet: assert property (req.read && req.periph != 8'h04 |=> !rvalid)
    else $error("foreign read answered");
  a_reserved_zero: assert property (rvalid |-> rdata[7:2] == 6'h00)
    else $error("reserved bits set");
  a_source_follow: assert property (hit && req.offset == 8'h00 |=>
    osc.source_internal == $past(req.wdata[0])) else $error("source bad");
  a_tile_pulse: assert property ($rose(tile_reset) |-> s_pulse)
    else $error("tile pulse length");
  a_reset_cause: assert property ($rose(tile_reset) |-> $changed(osc.source_internal))
    else $error("tile reset without change");
  a_speed_write: assert property (hit && req.offset == 8'h01 |=>
    osc.internal_slow == $past(req.wdata[1]) && osc.internal_enable == $past(req.wdata[0]))
    else $error("internal ctrl bad");
  a_crystal_write: assert property (hit && req.offset == 8'h02 |=>
    osc.crystal_bias == $past(req.wdata[1]) && osc.crystal_enable == $past(req.wdata[0]))
    else $error("crystal ctrl bad");
endmodule
bind oscillator_select_control osc_ctrl_properties osc_ctrl_properties_i (.clock, .rst, .req,
  .source_strap, .rdata, .rvalid, .osc, .tile_reset);

// file: testbench/oscillator_select_control_tb.sv
`timescale 1ns/1ps
module oscillator_select_control_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic source_strap = 1'b1;
  osc_ctrl_pkg::periph_req_t req = '0;
  logic [7:0] rdata;
  logic rvalid;
  osc_ctrl_pkg::osc_ctrl_t osc;
  logic tile_reset;
  logic [7:0] q;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int highs;
  // Rows: periph, offset, write data, expected read back
  logic [31:0] rows [10] = '{32'h05000001, 32'h05010001, 32'h05020003, 32'h0400FC00,
    32'h0401FE02, 32'h04010101, 32'h04000101, 32'h0402FC00, 32'h04020303, 32'h0403FF00};
  logic [7:0] tw [4] = '{8'h01, 8'h03, 8'h02, 8'h02};
  logic [7:0] te [4] = '{8'h00, 8'h00, 8'h04, 8'h00};
  oscillator_select_control oscillator_select_control_i (.clock, .rst, .req, .source_strap,
    .rdata, .rvalid, .osc, .tile_reset);
  initial forever #4 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Missing answer yields unknown data, so a silent read cannot pass
  task automatic access(input logic rd, input logic [7:0] p, o, d, output logic [7:0] r);
    req = '{read: rd, write: !rd, periph: p, offset: o, wdata: d};
    @(negedge clock);
    r = (rvalid === 1'b1) ? rdata : 8'hXX;
    req = '0;
    @(negedge clock);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    foreach (rows[i]) begin
      access(1'b0, rows[i][31:24], rows[i][23:16], rows[i][15:8], q);
      access(1'b1, 8'h04, rows[i][23:16], 8'h00, q);
      check(q, rows[i][7:0]);
    end
    access(1'b1, 8'h05, 8'h00, 8'h00, q);
    check(q, 8'hXX);
    foreach (tw[i]) begin
      highs = 0;
      fork
        access(1'b0, 8'h04, 8'h00, tw[i], q);
        repeat (8) begin
          @(negedge clock);
          highs += int'(tile_reset);
        end
      join
      check(8'(highs), te[i]);
    end
    access(1'b0, 8'h04, 8'h01, 8'hFE, q);
    rst = 1'b1;
    source_strap = 1'b0;
    @(negedge clock);
    check({3'h0, osc}, 8'h0B);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    access(1'b1, 8'h04, 8'h00, 8'h00, q);
    check(q, 8'h00);
    print_verdict();
  end
endmodule
